/* core/ebcmt_core.sv */
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps

// What this block does
// R01 - After good receive, add that packet's descriptor count to the buffer count.
// R02 - Software writes the decrement bit once per descriptor after reading the packet.
// R03 - Hardware increment at maximum leaves the count at maximum.
// R04 - Software decrement at zero leaves the count at zero.
// R05 - Simultaneous increment and decrement leave the count unchanged.
// R06 - Flow control on and count at maximum stalls receive until decremented.
// R07 - Flow control off lets receive DMA continue with count saturated.
// R08 - Pending flag follows non-zero count; interrupt only when its enable is set.
// R09 - Any write of the receive start pointer clears the count.
// R10 - Switching the module off keeps the count.
// R11 - Busy flag set while on or while a transaction is still finishing.
// R12 - Transmit busy follows transmission, forced zero when off.
// R13 - Test backpressure sends preamble for carrier sense, system packets still go.
// R14 - Test pause blocks transmit as if a non-zero pause were received.
// R15 - Short quanta makes each pause quantum one byte-time instead of 64.
// R16 - Registers take 16-bit and 32-bit accesses and ignore 8-bit ones.
// R17 - Test register bits 31 to 3 read as zero.
// R18 - A decrement write with no increment in the same cycle lowers the count by exactly one, within limits.
module ebcmt_core (
  // Clock, enable and reset.
  input  wire logic                    clk,
  input  wire logic                    clk_en,
  input  wire logic                    arst_n,
  // Register port.
  input  wire ebcmt_pkg::ebcmt_bus_type bus,
  output logic [31:0]                  rdata,
  // Receive side.
  input  wire logic                    rx_pkt_done,
  input  wire logic [7:0]              rx_pkt_desc,
  input  wire logic                    rx_active,
  output logic                         rx_stall,
  output logic                         rx_dma_run,
  // Transmit side.
  input  wire logic                    tx_active,
  input  wire logic                    xact_pending,
  input  wire logic                    pause_rx_nonzero,
  input  wire logic                    byte_tick,
  output logic                         tx_inhibit,
  output logic                         tx_preamble,
  output logic                         quantum_tick,
  // Module status and interrupt.
  output logic                         module_on,
  output logic                         irq
);
  import ebcmt_pkg::*;

  logic [7:0]           rx_buffer_count_r;
  logic [7:0]           rx_buffer_count_nxt;
  logic                 on_r;
  logic                 afc_r;
  logic [TEST_WIDTH-1:0] test_r;
  logic [IRQ_WIDTH-1:0] irq_stat_r;
  logic [IRQ_WIDTH-1:0] irq_mask_r;
  logic [6:0]           quanta_cnt_r;
  logic [31:0]          rdata_nxt;
  logic                 size_ok;
  logic                 wr_ok;
  logic                 rd_ok;
  logic                 dec_req;
  logic                 inc_req;
  logic                 ptr_wr;
  logic                 module_busy_flag;
  logic                 tx_busy_flag;
  logic                 packet_pending_flag;
  logic [8:0]           inc_sum;
  logic [IRQ_WIDTH-1:0] irq_event;

  ////////////////////////////////////////////////////////////////////////////
  // Access decode.

  assign size_ok = (bus.size == SIZE_16) || (bus.size == SIZE_32);  // R16
  assign wr_ok   = bus.wr && size_ok;  // R16
  assign rd_ok   = bus.rd && size_ok;  // R16
  assign dec_req = wr_ok && (bus.addr == ADDR_CONTROL) && bus.wdata[CTL_DEC_BIT];  // R18
  assign ptr_wr  = wr_ok && (bus.addr == ADDR_RXSTART);
  assign inc_req = rx_pkt_done && (rx_pkt_desc != CNT_ZERO);  // R01

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer count.

  assign inc_sum = {1'b0, rx_buffer_count_r} + {1'b0, rx_pkt_desc};

  always_comb begin
    rx_buffer_count_nxt = rx_buffer_count_r;
    if (ptr_wr) begin
      rx_buffer_count_nxt = CNT_ZERO;  // R09
    end else if (inc_req && dec_req) begin
      rx_buffer_count_nxt = rx_buffer_count_r;  // R05
    end else if (inc_req) begin
      rx_buffer_count_nxt = inc_sum[8] ? CNT_MAX : inc_sum[7:0];  // R01 R03
    end else if (dec_req && (rx_buffer_count_r != CNT_ZERO)) begin
      rx_buffer_count_nxt = rx_buffer_count_r - 8'h01;  // R04 R18
    end
  end

  // The count has no term on the on bit, so switching off keeps it.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_buffer_count_r <= CNT_ZERO;
    end else if (clk_en) begin
      rx_buffer_count_r <= rx_buffer_count_nxt;  // R10
    end
  end

  assign packet_pending_flag = (rx_buffer_count_r != CNT_ZERO);  // R08
  assign rx_stall   = afc_r && (rx_buffer_count_r == CNT_MAX);  // R06
  assign rx_dma_run = on_r && !rx_stall;  // R07

  ////////////////////////////////////////////////////////////////////////////
  // Control and test registers.

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      on_r  <= 1'b0;
      afc_r <= 1'b0;
    end else if (clk_en && wr_ok && (bus.addr == ADDR_CONTROL)) begin
      on_r  <= bus.wdata[CTL_ON_BIT];
      afc_r <= bus.wdata[CTL_AFC_BIT];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      test_r <= '0;
    end else if (clk_en && wr_ok && (bus.addr == ADDR_TEST)) begin
      test_r <= bus.wdata[TEST_WIDTH-1:0];
    end
  end

  assign module_on        = on_r;
  assign module_busy_flag = on_r || xact_pending;  // R11
  assign tx_busy_flag     = on_r && tx_active;  // R12

  ////////////////////////////////////////////////////////////////////////////
  // MAC test behaviour.

  // Backpressure drives preamble, but yields to a real system packet.
  assign tx_preamble = on_r && test_r[TEST_BP_BIT] && !tx_active;  // R13
  assign tx_inhibit  = test_r[TEST_PAUSE_BIT] || pause_rx_nonzero;  // R14

  // Quantum timer: one tick each 64 byte-times, or each byte-time when shortened.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      quanta_cnt_r <= '0;
    end else if (clk_en && byte_tick) begin
      if (test_r[TEST_SHORT_BIT] || (quanta_cnt_r >= QUANTA_LEN - QUANTA_ONE)) begin
        quanta_cnt_r <= '0;  // R15
      end else begin
        quanta_cnt_r <= quanta_cnt_r + QUANTA_ONE;
      end
    end
  end

  assign quantum_tick = byte_tick &&
                        (test_r[TEST_SHORT_BIT] || (quanta_cnt_r == QUANTA_LEN - QUANTA_ONE));  // R15

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky status, cleared by a read, set wins over clear.

  assign irq_event[IRQ_PEND_BIT] = packet_pending_flag;
  assign irq_event[IRQ_SAT_BIT]  = (rx_buffer_count_r == CNT_MAX);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_r <= '0;
    end else if (clk_en) begin
      if (rd_ok && (bus.addr == ADDR_IRQ_STAT)) begin
        irq_stat_r <= irq_event;
      end else begin
        irq_stat_r <= irq_stat_r | irq_event;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_mask_r <= '0;
    end else if (clk_en && wr_ok && (bus.addr == ADDR_IRQ_MASK)) begin
      irq_mask_r <= bus.wdata[IRQ_WIDTH-1:0];
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);  // R08

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the read strobe.

  always_comb begin
    rdata_nxt = WORD_ZERO;
    unique case (bus.addr)
      ADDR_STATUS: begin
        rdata_nxt[STAT_CNT_LSB +: 8]  = rx_buffer_count_r;
        rdata_nxt[STAT_BUSY_BIT]      = module_busy_flag;  // R11
        rdata_nxt[STAT_TXBSY_BIT]     = tx_busy_flag;  // R12
        rdata_nxt[STAT_RXBSY_BIT]     = on_r && rx_active;
      end
      ADDR_TEST: begin
        rdata_nxt[TEST_WIDTH-1:0] = test_r;  // R17
      end
      ADDR_CONTROL: begin
        rdata_nxt[CTL_ON_BIT]  = on_r;
        rdata_nxt[CTL_AFC_BIT] = afc_r;
      end
      ADDR_IRQ_STAT: begin
        rdata_nxt[IRQ_WIDTH-1:0] = irq_stat_r;
      end
      ADDR_IRQ_MASK: begin
        rdata_nxt[IRQ_WIDTH-1:0] = irq_mask_r;
      end
      default: begin
        rdata_nxt = WORD_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= WORD_ZERO;
    end else if (clk_en) begin
      rdata <= rd_ok ? rdata_nxt : WORD_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sat_no_wrap_a: assert property (clk_en && !ptr_wr && !dec_req && rx_buffer_count_r == CNT_MAX
    |=> rx_buffer_count_r == CNT_MAX) else $error("count wrapped past maximum"); // R03
  floor_no_wrap_a: assert property (clk_en && !ptr_wr && !inc_req && rx_buffer_count_r == CNT_ZERO
    |=> rx_buffer_count_r == CNT_ZERO) else $error("count wrapped below zero"); // R04
  collide_hold_a: assert property (clk_en && inc_req && dec_req && !ptr_wr
    |=> $stable(rx_buffer_count_r)) else $error("collision changed count"); // R05
  ptr_clear_a: assert property (clk_en && ptr_wr |=> rx_buffer_count_r == CNT_ZERO)
    else $error("pointer write did not clear count"); // R09
  dec_one_a: assert property (clk_en && dec_req && !inc_req && !ptr_wr && rx_buffer_count_r != CNT_ZERO
    |=> rx_buffer_count_r == $past(rx_buffer_count_r) - 8'h01) else $error("decrement not by one"); // R18
  inc_add_a: assert property (clk_en && inc_req && !dec_req && !ptr_wr && !inc_sum[8]
    |=> rx_buffer_count_r == $past(inc_sum[7:0])) else $error("increment wrong"); // R01
  stall_full_a: assert property (rx_stall == (afc_r && rx_buffer_count_r == CNT_MAX))
    else $error("stall mismatch"); // R06
  off_keep_a: assert property (clk_en && $fell(on_r) && !$past(ptr_wr) && !$past(inc_req) && !$past(dec_req)
    |-> $stable(rx_buffer_count_r)) else $error("switch-off changed count"); // R10
  tx_busy_flag_off_a: assert property (!on_r |-> !tx_busy_flag) else $error("tx busy while off"); // R12
  byte_read_a: assert property (bus.rd && bus.size == SIZE_8 && clk_en |=> rdata == WORD_ZERO)
    else $error("byte read answered"); // R16
  test_pause_a: assert property (test_r[TEST_PAUSE_BIT] |-> tx_inhibit) else $error("pause not inhibiting"); // R14

  ////////////////////////////////////////////////////////////////////////////
  // Count and pending checks.

  pend_flag_a: assert property ( // R08
    rx_buffer_count_r != CNT_ZERO |-> packet_pending_flag)
    else $error("pending flag low with count set");

  pend_sticky_a: assert property ( // R08
    clk_en && packet_pending_flag |=> irq_stat_r[IRQ_PEND_BIT])
    else $error("pending status bit not set");

  irq_masked_a: assert property ( // R08
    irq_mask_r == '0 |-> !irq)
    else $error("interrupt while fully masked");

  irq_raise_a: assert property ( // R08
    clk_en && packet_pending_flag && irq_mask_r[IRQ_PEND_BIT] && !(wr_ok && bus.addr == ADDR_IRQ_MASK)
    |=> irq)
    else $error("enabled pending interrupt missing");

  inc_sat_a: assert property ( // R03
    clk_en && inc_req && !dec_req && !ptr_wr && inc_sum[8] |=> rx_buffer_count_r == CNT_MAX)
    else $error("overflowing increment did not saturate");

  desc_zero_a: assert property ( // R01
    clk_en && rx_pkt_done && rx_pkt_desc == CNT_ZERO && !dec_req && !ptr_wr |=> $stable(rx_buffer_count_r))
    else $error("empty report changed count");

  stall_hold_a: assert property ( // R06
    clk_en && rx_stall && !ptr_wr && !(wr_ok && bus.addr == ADDR_CONTROL) |=> rx_stall)
    else $error("stall released without decrement");

  dma_free_a: assert property ( // R07
    on_r && !afc_r |-> rx_dma_run)
    else $error("receive DMA halted with flow control off");

  ////////////////////////////////////////////////////////////////////////////
  // Busy flag checks.

  busy_on_a: assert property ( // R11
    on_r |-> module_busy_flag)
    else $error("busy low while on");

  busy_drain_a: assert property ( // R11
    xact_pending |-> module_busy_flag)
    else $error("busy low while finishing");

  busy_idle_a: assert property ( // R11
    !on_r && !xact_pending |-> !module_busy_flag)
    else $error("busy high while idle");

  on_write_a: assert property ( // R11
    clk_en && wr_ok && bus.addr == ADDR_CONTROL |=> on_r == $past(bus.wdata[CTL_ON_BIT]))
    else $error("on bit not stored");

  tx_busy_flag_on_a: assert property ( // R12
    on_r && tx_active |-> tx_busy_flag)
    else $error("tx busy low while sending");

  ////////////////////////////////////////////////////////////////////////////
  // MAC test control checks.

  bp_pre_a: assert property ( // R13
    on_r && test_r[TEST_BP_BIT] && !tx_active |-> tx_preamble)
    else $error("backpressure preamble missing");

  bp_yield_a: assert property ( // R13
    tx_active |-> !tx_preamble)
    else $error("preamble over a system packet");

  pause_rx_a: assert property ( // R14
    pause_rx_nonzero |-> tx_inhibit)
    else $error("received pause not inhibiting");

  pause_idle_a: assert property ( // R14
    !test_r[TEST_PAUSE_BIT] && !pause_rx_nonzero |-> !tx_inhibit)
    else $error("inhibit without a pause");

  short_tick_a: assert property ( // R15
    test_r[TEST_SHORT_BIT] && byte_tick |-> quantum_tick)
    else $error("short quantum not one byte-time");

  quanta_gap_a: assert property ( // R15
    !test_r[TEST_SHORT_BIT] && quantum_tick |-> quanta_cnt_r == QUANTA_LEN - QUANTA_ONE)
    else $error("quantum ended early");

  no_tick_a: assert property ( // R15
    !byte_tick |-> !quantum_tick)
    else $error("quantum without byte time");

  ////////////////////////////////////////////////////////////////////////////
  // Register access checks.

  test_ignore_a: assert property ( // R16
    clk_en && bus.wr && bus.size == SIZE_8 && bus.addr == ADDR_TEST |=> $stable(test_r))
    else $error("byte write changed test register");

  ctl_ignore_a: assert property ( // R16
    clk_en && bus.wr && bus.size == SIZE_8 && bus.addr == ADDR_CONTROL |=> $stable(on_r))
    else $error("byte write changed control");

  cnt_ignore_a: assert property ( // R16
    clk_en && bus.wr && bus.size == SIZE_8 && !inc_req |=> $stable(rx_buffer_count_r))
    else $error("byte write changed count");

  rdata_idle_a: assert property ( // R16
    clk_en && !rd_ok |=> rdata == WORD_ZERO)
    else $error("read data without a read");

  test_upper_a: assert property ( // R17
    clk_en && rd_ok && bus.addr == ADDR_TEST |=> rdata[31:TEST_WIDTH] == '0)
    else $error("test register upper bits set");

  stat_cnt_a: assert property ( // R01
    clk_en && rd_ok && bus.addr == ADDR_STATUS |=> rdata[STAT_CNT_LSB +: 8] == $past(rx_buffer_count_r))
    else $error("status count field wrong");

  short_c: cover property (test_r[TEST_SHORT_BIT] && quantum_tick);

  cnt_full_c: cover property (rx_buffer_count_r == CNT_MAX ##1 rx_buffer_count_r != CNT_MAX);
  collide_c: cover property (inc_req && dec_req);
  irq_c: cover property ($rose(irq));
  stall_c: cover property ($rose(rx_stall));

endmodule

/* core/ebcmt_pkg.sv */
package ebcmt_pkg;

  // Register word addresses on the plain register port.
  localparam logic [3:0] ADDR_STATUS   = 4'h0;
  localparam logic [3:0] ADDR_TEST     = 4'h1;
  localparam logic [3:0] ADDR_CONTROL  = 4'h2;
  localparam logic [3:0] ADDR_RXSTART  = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;

  // Access size codes on the size port.
  localparam logic [1:0] SIZE_8  = 2'h0;
  localparam logic [1:0] SIZE_16 = 2'h1;
  localparam logic [1:0] SIZE_32 = 2'h2;

  // Status register fields.
  localparam int STAT_CNT_LSB   = 16;
  localparam int STAT_BUSY_BIT  = 7;
  localparam int STAT_TXBSY_BIT = 6;
  localparam int STAT_RXBSY_BIT = 5;

  // Control register fields.
  localparam int CTL_ON_BIT  = 15;
  localparam int CTL_DEC_BIT = 0;
  localparam int CTL_AFC_BIT = 1;

  // Test register fields.
  localparam int TEST_BP_BIT    = 2;
  localparam int TEST_PAUSE_BIT = 1;
  localparam int TEST_SHORT_BIT = 0;
  localparam int TEST_WIDTH     = 3;

  // Interrupt status bits.
  localparam int IRQ_PEND_BIT = 0;
  localparam int IRQ_SAT_BIT  = 1;
  localparam int IRQ_WIDTH    = 2;

  localparam logic [7:0]  CNT_MAX    = 8'hFF;
  localparam logic [7:0]  CNT_ZERO   = 8'h00;
  localparam logic [6:0]  QUANTA_LEN = 7'h40;
  localparam logic [6:0]  QUANTA_ONE = 7'h01;
  localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [1:0]  size;
    logic [31:0] wdata;
  } ebcmt_bus_type;

endpackage

/* test/ebcmt_phy_model.sv */
`timescale 1ns/100ps

// Link-side stand-in: reports good frames and paces byte times.
module ebcmt_phy_model (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Requests from the bench.
  input  wire logic       pkt_req,
  input  wire logic [7:0] pkt_desc,
  // Receive report and pacing.
  output logic            rx_pkt_done,
  output logic [7:0]      rx_pkt_desc,
  output logic            rx_active,
  output logic            byte_tick
);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_pkt_done <= 1'b0;
      rx_pkt_desc <= 8'h00;
      rx_active   <= 1'b0;
      byte_tick   <= 1'b0;
    end else begin
      rx_pkt_done <= pkt_req;
      rx_active   <= pkt_req;
      // Outside a report the descriptor lines flip to the inverse of their last value each cycle.
      rx_pkt_desc <= pkt_req ? pkt_desc : ~rx_pkt_desc;
      byte_tick   <= ~byte_tick;
    end
  end
endmodule

/* test/ebcmt_core_tb.sv */
`timescale 1ns/100ps

module ebcmt_core_tb;
  import ebcmt_pkg::*;
  logic clk, arst_n, req, tx_act, xact, pz, rx_done, rx_act, btick;
  logic rx_stall, rx_dma_run, tx_inh, tx_pre, qtick, mod_on, irq;
  logic [7:0] desc, rx_desc;
  logic [31:0] rdata, q, ctl;
  ebcmt_bus_type bus;
  int n_errors, checks_done, cnt, nq;

  ebcmt_phy_model phy (.clk(clk), .arst_n(arst_n), .pkt_req(req), .pkt_desc(desc), .rx_pkt_done(rx_done),
    .rx_pkt_desc(rx_desc), .rx_active(rx_act), .byte_tick(btick));
  ebcmt_core dut (.clk(clk), .clk_en(1'b1), .arst_n(arst_n), .bus(bus), .rdata(rdata), .rx_pkt_done(rx_done),
    .rx_pkt_desc(rx_desc), .rx_active(rx_act), .rx_stall(rx_stall), .rx_dma_run(rx_dma_run), .tx_active(tx_act),
    .xact_pending(xact), .pause_rx_nonzero(pz), .byte_tick(btick), .tx_inhibit(tx_inh), .tx_preamble(tx_pre),
    .quantum_tick(qtick), .module_on(mod_on), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic acc(input logic w, input logic [3:0] a, input logic [1:0] s, input logic [31:0] d);
    @(posedge clk);
    bus <= '{wr: w, rd: !w, addr: a, size: s, wdata: d};
    @(posedge clk);
    bus <= '0;
    #1 q = rdata;
  endtask

  task automatic cnt_is(input int e);
    acc(1'b0, ADDR_STATUS, SIZE_32, 32'h0);
    chk({24'h0, q[23:16]}, e);
  endtask

  task automatic pkt(input logic [7:0] d);
    @(posedge clk);
    req <= 1'b1;
    desc <= d;
    @(posedge clk);
    req <= 1'b0;
    repeat (2) @(posedge clk);
    #1 cnt = (cnt + d > 255) ? 255 : cnt + d;
  endtask

  task automatic dec();
    acc(1'b1, ADDR_CONTROL, SIZE_32, ctl | 32'h0000_0001);
    cnt = (cnt > 0) ? cnt - 1 : 0;
  endtask

  task automatic qcount(input logic [31:0] t, input int e);
    acc(1'b1, ADDR_TEST, SIZE_32, t);
    nq = 0;
    repeat (256) begin
      @(negedge clk);
      if (qtick === 1'b1) nq++;
    end
    chk(nq, e);
  endtask

  initial begin
    #400000 n_errors++;
    give_verdict();
  end

  initial begin
    {arst_n, req, tx_act, xact, pz} = '0;
    {desc, cnt, n_errors, checks_done} = '0;
    bus = '0;
    ctl = 32'h0000_8002;
    void'($urandom(55056));
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    ////////////////////////////////////////////////////////////////////////////
    acc(1'b1, ADDR_TEST, SIZE_32, 32'hFFFF_FFFF);
    acc(1'b0, ADDR_TEST, SIZE_32, 32'h0);
    chk(q, 32'h0000_0007);
    acc(1'b1, ADDR_TEST, SIZE_8, 32'h0);
    acc(1'b0, ADDR_TEST, SIZE_16, 32'h0);
    chk(q, 32'h0000_0007);
    acc(1'b0, ADDR_TEST, SIZE_8, 32'h0);
    chk(q, 32'h0);
    acc(1'b1, ADDR_TEST, SIZE_16, 32'h0);
    acc(1'b0, ADDR_TEST, SIZE_32, 32'h0);
    chk(q, 32'h0);
    $display("register access test done");
    ////////////////////////////////////////////////////////////////////////////
    acc(1'b1, ADDR_CONTROL, SIZE_32, ctl);
    chk(mod_on, 1'b1);
    @(posedge clk);
    tx_act <= 1'b1;
    acc(1'b0, ADDR_STATUS, SIZE_32, 32'h0);
    chk(q[7:6], 2'b11);
    @(posedge clk);
    tx_act <= 1'b0;
    while (cnt < 255) begin
      pkt(8'($urandom_range(1, 64)));
      cnt_is(cnt);
    end
    pkt(8'h09);
    cnt_is(255);
    chk(rx_stall, 1'b1);
    dec();
    cnt_is(cnt);
    chk(rx_stall, 1'b0);
    @(posedge clk);
    req <= 1'b1;
    desc <= 8'h03;
    @(posedge clk);
    req <= 1'b0;
    bus <= '{wr: 1'b1, rd: 1'b0, addr: ADDR_CONTROL, size: SIZE_32, wdata: ctl | 32'h0000_0001};
    @(posedge clk);
    bus <= '0;
    cnt_is(cnt);
    $display("count saturation test done");
    ////////////////////////////////////////////////////////////////////////////
    ctl = 32'h0000_8000;
    acc(1'b1, ADDR_CONTROL, SIZE_32, ctl);
    pkt(8'h05);
    cnt_is(255);
    chk({rx_stall, rx_dma_run}, 2'b01);
    acc(1'b1, ADDR_IRQ_MASK, SIZE_32, 32'h0000_0001);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b1);
    acc(1'b0, ADDR_IRQ_STAT, SIZE_32, 32'h0);
    chk(q[0], 1'b1);
    acc(1'b1, ADDR_IRQ_MASK, SIZE_32, 32'h0);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b0);
    $display("flow control and interrupt test done");
    ////////////////////////////////////////////////////////////////////////////
    ctl = 32'h0;
    @(posedge clk);
    xact <= 1'b1;
    tx_act <= 1'b1;
    acc(1'b1, ADDR_CONTROL, SIZE_32, ctl);
    acc(1'b0, ADDR_STATUS, SIZE_32, 32'h0);
    chk(q[7:6], 2'b10);
    chk(mod_on, 1'b0);
    @(posedge clk);
    xact <= 1'b0;
    tx_act <= 1'b0;
    acc(1'b0, ADDR_STATUS, SIZE_32, 32'h0);
    chk(q[7], 1'b0);
    cnt_is(255);
    dec();
    cnt_is(cnt);
    acc(1'b1, ADDR_RXSTART, SIZE_32, $urandom);
    cnt = 0;
    cnt_is(0);
    dec();
    cnt_is(0);
    $display("switch-off and pointer test done");
    ////////////////////////////////////////////////////////////////////////////
    acc(1'b1, ADDR_CONTROL, SIZE_32, 32'h0000_8000);
    acc(1'b1, ADDR_TEST, SIZE_32, 32'h0000_0002);
    #1 chk(tx_inh, 1'b1);
    acc(1'b1, ADDR_TEST, SIZE_32, 32'h0000_0004);
    #1 chk({tx_inh, tx_pre}, 2'b01);
    @(posedge clk);
    tx_act <= 1'b1;
    @(negedge clk);
    chk(tx_pre, 1'b0);
    @(posedge clk);
    tx_act <= 1'b0;
    qcount(32'h0000_0001, 128);
    qcount(32'h0000_0000, 2);
    $display("mac test controls done");
    give_verdict();
  end
endmodule
